// file: design/azs_defines.vh
`ifndef AZS_DEFINES_VH
`define AZS_DEFINES_VH
// ----------------------------------------
// Port map and codes
// ----------------------------------------
`define AZS_ADDR_DATA      8'hE4
`define AZS_ADDR_TRIM      8'hE5
`define AZS_ADDR_SWITCH    8'hE6
`define AZS_ADDR_CTRL      8'hE7
`define AZS_CTRL_MODE0     8'h90
`define AZS_PTR_INIT       8'h80
`define AZS_TRIM_INIT      8'h7F
`define AZS_SW_ZEROING     8'h01
`define AZS_SW_TOGGLE      8'h03
`define AZS_HANDLER_VECTOR 16'h3C3D
`define AZS_STEPS          4'h8
`define AZS_WR_NS          20
`define AZS_WR_CYC         ((`AZS_WR_NS + 4) / 5)
`endif

// file: design/azs_sync.v
`timescale 1ns/1ps
`default_nettype none
module azs_sync #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input  wire             clk,
  input  wire             rst,
  // Data
  input  wire [WIDTH-1:0] d,
  output reg  [WIDTH-1:0] q
);
  reg [WIDTH-1:0] meta_reg;
  always @(posedge clk) begin
    if (rst) begin
      meta_reg <= {WIDTH{1'b0}};
      q        <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule // azs_sync
`default_nettype wire

// file: design/azs_sequencer.v
// What this block does
// - The port unit is first programmed for basic mode 0 with no handshake.
// - The data port is set as input and the trim and switch ports as outputs.
// - Two switch-port bits drive the short and signal switches, always opposite.
// - Zeroing runs with the short switch closed, then real conversion uses the signal switch.
// - The eight-bit trim code is held on the trim port, one bit per DAC resistor.
// - Every port line is inverted by buffers, so all data is inverted on the way.
// - A zero result clears the trim bit under test.
// - A nonzero result sets the trim bit under test.
// - Exactly eight approximation steps are run, then zeroing ends.
// - The converter and the input port share the data address.
// - Trim, switch and control ports follow at the next three addresses.
// - The done interrupt vectors to the fixed handler that reads the converter.
// - Zeroing starts with the bit pointer at its top bit and the trim code at its initial value.
// - At the end both switch bits are toggled together in one write.
`timescale 1ns/1ps
`default_nettype none
`include "azs_defines.vh"
module azs_sequencer #(
  parameter WR_CYCLES = `AZS_WR_CYC
) (
  // Clock and reset
  input  wire       clk,
  input  wire       rst,
  // User side
  input  wire       start,
  input  wire       convert,
  output reg        busy,
  output reg        zeroed,
  output reg  [7:0] sample,
  output reg        sample_valid,
  output reg  [7:0] trim_code,
  // Port-unit bus, all lines through inverting buffers
  output reg  [7:0] io_addr_n,
  output reg  [7:0] io_wdata_n,
  output reg        io_wr_n,
  output reg        io_rd_n,
  input  wire [7:0] io_rdata_n,
  // Converter done, active low at the pin
  input  wire       conversion_done_irq_n,
  // Handler address taken on interrupt acknowledge
  output reg  [15:0] vector_addr
);
  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam S_IDLE   = 4'd0;
  localparam S_CFG    = 4'd1;
  localparam S_SWZ    = 4'd2;
  localparam S_TRIM   = 4'd3;
  localparam S_START  = 4'd4;
  localparam S_WAIT   = 4'd5;
  localparam S_READ   = 4'd6;
  localparam S_EVAL   = 4'd7;
  localparam S_SWN    = 4'd8;
  localparam S_NORM   = 4'd9;
  localparam S_NSTART = 4'd10;
  localparam S_NWAIT  = 4'd11;
  localparam S_NREAD  = 4'd12;
  localparam S_DONE   = 4'd13;

  reg [3:0]  state_reg;
  reg [3:0]  state_next;
  reg [7:0]  ptr_reg;
  reg [7:0]  sw_reg;
  reg [3:0]  step_reg;
  reg [7:0]  cnt_reg;
  reg        phase_reg;
  wire       irq_n_s;
  wire [7:0] rdata_n_s;

  azs_sync #(.WIDTH(9)) u_sync (
    .clk (clk),
    .rst (rst),
    .d   ({conversion_done_irq_n, io_rdata_n}),
    .q   ({irq_n_s, rdata_n_s})
  );

  // Bus cycle: drive address and data, hold strobe for WR_CYCLES + 1 cycles, then release.
  // Each access starts at least one idle cycle after the last release, because the port unit
  // latches on the rising strobe and would lose a write that runs straight into the next.
  wire cycle_done = phase_reg && (cnt_reg == 8'h00);

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      state_reg    <= S_IDLE;
      ptr_reg      <= 8'h00;
      sw_reg       <= 8'h00;
      trim_code    <= 8'h00;
      step_reg     <= 4'h0;
      cnt_reg      <= 8'h00;
      phase_reg    <= 1'b0;
      io_addr_n    <= 8'hFF;
      io_wdata_n   <= 8'hFF;
      io_wr_n      <= 1'b1;
      io_rd_n      <= 1'b1;
      busy         <= 1'b0;
      zeroed       <= 1'b0;
      sample       <= 8'h00;
      sample_valid <= 1'b0;
      vector_addr  <= 16'h0000;
    end else begin
      sample_valid <= 1'b0;
      if (phase_reg) begin
        cnt_reg <= cnt_reg - 8'h01;
        if (cycle_done) begin
          phase_reg <= 1'b0;
          io_wr_n   <= 1'b1;
          io_rd_n   <= 1'b1;
        end
      end
      case (state_reg)
        S_IDLE: begin
          if (start) begin
            busy      <= 1'b1;
            zeroed    <= 1'b0;
            io_addr_n <= ~`AZS_ADDR_CTRL;
            io_wdata_n <= ~`AZS_CTRL_MODE0;
            io_wr_n   <= 1'b0;
            phase_reg <= 1'b1;
            cnt_reg   <= WR_CYCLES[7:0];
            state_reg <= S_CFG;
          end
        end
        S_CFG: if (!phase_reg) begin
          sw_reg     <= `AZS_SW_ZEROING;
          io_addr_n  <= ~`AZS_ADDR_SWITCH;
          io_wdata_n <= ~`AZS_SW_ZEROING;
          io_wr_n    <= 1'b0;
          phase_reg  <= 1'b1;
          cnt_reg    <= WR_CYCLES[7:0];
          ptr_reg    <= `AZS_PTR_INIT;
          trim_code  <= `AZS_TRIM_INIT;
          step_reg   <= 4'h0;
          state_reg  <= S_SWZ;
        end
        S_SWZ, S_EVAL: if (!phase_reg) begin
          io_addr_n  <= ~`AZS_ADDR_TRIM;
          io_wdata_n <= ~trim_code;
          io_wr_n    <= 1'b0;
          phase_reg  <= 1'b1;
          cnt_reg    <= WR_CYCLES[7:0];
          state_reg  <= S_TRIM;
        end
        S_TRIM: if (!phase_reg) begin
          io_addr_n  <= ~`AZS_ADDR_DATA;
          io_wr_n    <= 1'b0;
          phase_reg  <= 1'b1;
          cnt_reg    <= WR_CYCLES[7:0];
          state_reg  <= S_START;
        end
        S_START, S_NSTART: if (cycle_done) begin
          state_reg <= (state_reg == S_START) ? S_WAIT : S_NWAIT;
        end
        S_WAIT, S_NWAIT: if (!irq_n_s) begin
          vector_addr <= `AZS_HANDLER_VECTOR;
          io_addr_n   <= ~`AZS_ADDR_DATA;
          io_rd_n     <= 1'b0;
          phase_reg   <= 1'b1;
          cnt_reg     <= WR_CYCLES[7:0];
          state_reg   <= (state_reg == S_WAIT) ? S_READ : S_NREAD;
        end
        S_READ: if (cycle_done) begin
          // A zero result means the preamp output is negative.
          if (~rdata_n_s == 8'h00) begin
            trim_code <= trim_code & ~ptr_reg;
          end else begin
            trim_code <= trim_code | ptr_reg;
          end
          ptr_reg  <= ptr_reg >> 1;
          step_reg <= step_reg + 4'h1;
          if (step_reg == `AZS_STEPS - 4'h1) begin
            state_reg <= S_SWN;
          end else begin
            state_reg <= S_EVAL;
          end
        end
        S_SWN: begin
          // Final trim update goes out before the switches flip.
          if (!phase_reg) begin
            io_addr_n  <= ~`AZS_ADDR_TRIM;
            io_wdata_n <= ~trim_code;
            io_wr_n    <= 1'b0;
            phase_reg  <= 1'b1;
            cnt_reg    <= WR_CYCLES[7:0];
            state_reg  <= S_NORM;
          end
        end
        S_NORM: if (!phase_reg) begin
          sw_reg     <= sw_reg ^ `AZS_SW_TOGGLE;
          io_addr_n  <= ~`AZS_ADDR_SWITCH;
          io_wdata_n <= ~(sw_reg ^ `AZS_SW_TOGGLE);
          io_wr_n    <= 1'b0;
          phase_reg  <= 1'b1;
          cnt_reg    <= WR_CYCLES[7:0];
          state_reg  <= S_DONE;
        end
        S_DONE: if (cycle_done) begin
          // Busy stays high until the switch write is over, so no request can cut it short.
          zeroed     <= 1'b1;
          busy       <= 1'b0;
          state_reg  <= S_IDLE;
        end
        S_NREAD: if (cycle_done) begin
          sample       <= ~rdata_n_s;
          sample_valid <= 1'b1;
          busy         <= 1'b0;
          state_reg    <= S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
      // Normal conversion keeps the trim code untouched.
      if (state_reg == S_IDLE && !start && convert && zeroed && !phase_reg) begin
        busy      <= 1'b1;
        io_addr_n <= ~`AZS_ADDR_DATA;
        io_wr_n   <= 1'b0;
        phase_reg <= 1'b1;
        cnt_reg   <= WR_CYCLES[7:0];
        state_reg <= S_NSTART;
      end
    end
  end
endmodule // azs_sequencer
`default_nettype wire

// file: verif/azs_adc_model.sv
`timescale 1ns/1ps
`default_nettype none
module azs_adc_model (
  input  wire logic       clk, io_wr_n, io_rd_n,
  input  wire logic [7:0] io_addr_n, io_wdata_n, off, sig,
  input  wire logic [5:0] lat,
  output var  logic       irq_n,
  output wire logic [7:0] io_rdata_n
);
  wire  [7:0] a = ~io_addr_n;
  logic [7:0] trim_reg, sw_reg, res_reg;
  logic [7:0] pat_reg = 8'h00;
  logic [6:0] cnt_reg = 7'h00;
  logic       wr_d = 1'b1, rd_d = 1'b1;
  initial irq_n = 1'b1;
  // Lines not being read toggle every cycle, so a stale sample never passes.
  assign io_rdata_n = (!io_rd_n && a == 8'hE4) ? ~res_reg : pat_reg;
  always @(posedge clk) begin
    wr_d <= io_wr_n;
    rd_d <= io_rd_n;
    pat_reg <= ~pat_reg;
    if (cnt_reg != 7'h00) cnt_reg <= cnt_reg - 7'h01;
    if (cnt_reg == 7'h01) irq_n <= 1'b0;
    if (io_rd_n && !rd_d && a == 8'hE4) irq_n <= 1'b1;
    if (io_wr_n && !wr_d) begin
      if (a == 8'hE5) trim_reg <= ~io_wdata_n;
      if (a == 8'hE6) sw_reg <= ~io_wdata_n;
      if (a == 8'hE4) begin
        cnt_reg <= {1'b0, lat} + 7'h02;
        res_reg <= sw_reg[1] ? sig : (off > trim_reg ? off - trim_reg : 8'h00);
      end
    end
  end
endmodule // azs_adc_model
`default_nettype wire

// file: verif/azs_checker.sv
`timescale 1ns/1ps
`default_nettype none
module azs_checker (
  input wire logic        clk, rst, start, convert, busy, zeroed, sample_valid,
  input wire logic        io_wr_n, io_rd_n, conversion_done_irq_n,
  input wire logic [7:0]  sample, trim_code, io_addr_n, io_wdata_n, io_rdata_n,
  input wire logic [15:0] vector_addr
);
  wire  [7:0] a = ~io_addr_n;
  wire  [7:0] d = ~io_wdata_n;
  wire        w = !io_wr_n;
  logic [3:0] n_reg;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  always @(posedge clk) begin
    if (rst || (start && !busy)) n_reg <= 4'h0;
    else if ($fell(io_wr_n) && a == 8'hE4) n_reg <= n_reg + 4'h1;
  end
  AST_WR_LEN: assert property ($fell(io_wr_n) |-> (!io_wr_n) [*5] ##1 io_wr_n)
    else $error("write strobe length");
  AST_RD_PORT: assert property (!io_rd_n |-> a == 8'hE4)
    else $error("read off data port");
  AST_CTRL: assert property (w && a == 8'hE7 |-> d == 8'h90)
    else $error("control word");
  AST_SWITCH: assert property (w && a == 8'hE6 |-> d inside {8'h01, 8'h02})
    else $error("switch code");
  AST_SHORT: assert property (w && a == 8'hE6 && d == 8'h01 |-> busy && !zeroed)
    else $error("short switch outside zeroing");
  AST_TRIM_OUT: assert property (w && a == 8'hE5 |-> d == trim_code)
    else $error("trim port data");
  AST_HOLD: assert property (zeroed && $past(zeroed) |-> $stable(trim_code))
    else $error("trim moved");
  AST_VECTOR: assert property ($changed(vector_addr) |-> vector_addr == 16'h3C3D)
    else $error("vector");
  AST_IRQ_READ: assert property ($fell(io_rd_n) |-> !conversion_done_irq_n)
    else $error("read before done");
  AST_STEPS: assert property ($rose(zeroed) |-> n_reg == 4'h8)
    else $error("step count");
  cover property ($rose(zeroed));
  cover property (sample_valid);
  cover property (w && a == 8'hE6 && d == 8'h02);
endmodule // azs_checker
bind azs_sequencer azs_checker u_chk (
  .clk                   (clk),
  .rst                   (rst),
  .start                 (start),
  .convert               (convert),
  .busy                  (busy),
  .zeroed                (zeroed),
  .sample_valid          (sample_valid),
  .io_wr_n               (io_wr_n),
  .io_rd_n               (io_rd_n),
  .conversion_done_irq_n (conversion_done_irq_n),
  .sample                (sample),
  .trim_code             (trim_code),
  .io_addr_n             (io_addr_n),
  .io_wdata_n            (io_wdata_n),
  .io_rdata_n            (io_rdata_n),
  .vector_addr           (vector_addr)
);
`default_nettype wire

// file: verif/azs_sequencer_test.sv
`timescale 1ns/1ps
`default_nettype none
module azs_sequencer_test;
  logic        clk = 1'b0, rst = 1'b1, start = 1'b0, convert = 1'b0, z_d = 1'b0;
  logic [7:0]  off = 8'h00, sig = 8'h00;
  logic [5:0]  lat = 6'h01;
  logic [31:0] seed = 32'h6964;
  logic [15:0] exp_q[$];
  int          err_total = 0, cmp_count = 0;
  wire         busy, zeroed, sample_valid, io_wr_n, io_rd_n, irq_n;
  wire  [7:0]  sample, trim_code, io_addr_n, io_wdata_n, io_rdata_n;
  wire  [15:0] vector_addr;
  always #2.5 clk = ~clk;
  azs_sequencer dut (.clk(clk), .rst(rst), .start(start), .convert(convert), .busy(busy),
    .zeroed(zeroed), .sample(sample), .sample_valid(sample_valid), .trim_code(trim_code),
    .io_addr_n(io_addr_n), .io_wdata_n(io_wdata_n), .io_wr_n(io_wr_n), .io_rd_n(io_rd_n),
    .io_rdata_n(io_rdata_n), .conversion_done_irq_n(irq_n), .vector_addr(vector_addr));
  azs_adc_model adc (.clk(clk), .io_wr_n(io_wr_n), .io_rd_n(io_rd_n), .io_addr_n(io_addr_n),
    .io_wdata_n(io_wdata_n), .off(off), .sig(sig), .lat(lat), .irq_n(irq_n), .io_rdata_n(io_rdata_n));
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    cmp_count++;
    if (seen !== want) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask
  task automatic results;
    $display("errors=%0d checks=%0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic run(input logic go, input logic cv);
    int n;
    n = 0;
    start = go;
    convert = cv;
    @(posedge clk);
    #1 start = 1'b0;
    convert = 1'b0;
    @(posedge clk);
    while (busy !== 1'b0 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    #1;
    if (n >= 4000) begin
      err_total++;
      results();
    end
  endtask
  // Reference approximation: a conversion reads nonzero only while the offset exceeds the trim.
  function automatic logic [7:0] exp_trim(input logic [7:0] o);
    logic [7:0] t;
    t = 8'h7F;
    for (int b = 7; b >= 0; b--) t[b] = (o > t);
    return t;
  endfunction
  // The watcher pairs each result with the oldest note.
  // Outputs are looked at on the falling edge, where they have settled.
  always @(negedge clk) begin
    z_d <= zeroed;
    if (zeroed === 1'b1 && z_d === 1'b0) begin
      check({15'h0000, exp_q.size() != 0}, 16'h0001);
      if (exp_q.size() != 0) check({8'h00, trim_code}, exp_q.pop_front());
    end
    if (sample_valid === 1'b1) begin
      check({15'h0000, exp_q.size() != 0}, 16'h0001);
      if (exp_q.size() != 0) check({8'h00, sample}, exp_q.pop_front());
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    run(1'b0, 1'b1);
    check({15'h0000, zeroed}, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      off = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : seed[7:0];
      lat = seed[13:8];
      sig = seed[23:16];
      exp_q.push_back({8'h00, exp_trim(off)});
      run(1'b1, 1'b0);
      exp_q.push_back({8'h00, sig});
      run(1'b0, 1'b1);
    end
    check(vector_addr, 16'h3C3D);
    results();
  end
endmodule // azs_sequencer_test
`default_nettype wire
